/* slsf_defs.vh */
`ifndef SLSF_DEFS_VH
`define SLSF_DEFS_VH
// Behaviour
// - voltage reference below start threshold flags loss
// - current reference below 4 mA flags loss
// - current reference spans 4 to 20 mA
// - loss flag clears itself when reference recovers
// - loss is indication only, no trip
// - loss flag evaluated in stop and run
// - loss detect only when source select is 01
// - set stage request in run below low limit
// - clear stage request above high limit
// - clear stage request on run to stop
// - stage request uses pid feedback and limits
// - limits carry no alarm meaning
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SLSF_OFS_CTRL      8'h00
`define SLSF_OFS_START_THR 8'h04
`define SLSF_OFS_PV_HIGH   8'h08
`define SLSF_OFS_PV_LOW    8'h0c
`define SLSF_OFS_OUT_SEL   8'h10
`define SLSF_OFS_STATUS    8'h14
`define SLSF_OFS_IRQ_STAT  8'h18
`define SLSF_OFS_IRQ_MASK  8'h1c
`define SLSF_OFS_VREF      8'h20
`define SLSF_OFS_IREF      8'h24
`define SLSF_OFS_PV        8'h28
// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define SLSF_CTRL_SRC_LSB  0
`define SLSF_CTRL_PIDF_LSB 2
`define SLSF_CTRL_PID_EN   4
`define SLSF_ST_LOSS       0
`define SLSF_ST_STAGE      1
`define SLSF_ST_RUN        2
`define SLSF_IRQ_LOSS_SET  0
`define SLSF_IRQ_LOSS_CLR  1
`define SLSF_IRQ_STAGE_SET 2
`define SLSF_IRQ_STAGE_CLR 3
// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define SLSF_SRC_ANALOG    2'h1
`define SLSF_FN_LOSS       8'h06
`define SLSF_FN_STAGE      8'h07
`define SLSF_RST_CTRL      5'h11
`define SLSF_RST_START_THR 12'h000
`define SLSF_RST_PV_HIGH   12'hfff
`define SLSF_RST_PV_LOW    12'h000
`define SLSF_RST_OUT_SEL   8'h06
// 4 mA of a 0..20 mA full-scale 12-bit converter: 4095*4/20
`define SLSF_IREF_4MA      12'h333
`define SLSF_IREF_20MA     12'hfff
`endif

/* slsf_sync.v */
module slsf_sync #(
  parameter W = 12
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // slsf_sync

/* slsf_stage.v */
module slsf_stage #(
  parameter W = 12
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // inputs
  input  wire         run,
  input  wire         enable,
  input  wire [W-1:0] pv,
  input  wire [W-1:0] low_limit,
  input  wire [W-1:0] high_limit,
  // output
  output reg          request
);
  localparam S_OFF = 2'b01;
  localparam S_ON  = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;

  always @* begin
    case (state_r)
      S_OFF: begin
        if (run && enable && (pv < low_limit))
          state_nxt = S_ON;
        else
          state_nxt = S_OFF;
      end
      S_ON: begin
        if (!run || !enable)
          state_nxt = S_OFF;
        else if (pv > high_limit)
          state_nxt = S_OFF;
        else
          state_nxt = S_ON;
      end
      default: state_nxt = S_OFF;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_OFF;
      request <= 1'b0;
    end else begin
      state_r <= state_nxt;
      request <= (state_nxt == S_ON);
    end
  end
endmodule // slsf_stage

/* slsf_top.v */
`include "slsf_defs.vh"
module slsf_top #(
  parameter W     = 12,
  parameter N_OUT = 3
) (
  // clock and reset
  input  wire             CORE_CLK,
  input  wire             RST,
  // wishbone slave
  input  wire             WB_CYC_I,
  input  wire             WB_STB_I,
  input  wire             WB_WE_I,
  input  wire [7:0]       WB_ADR_I,
  input  wire [3:0]       WB_SEL_I,
  input  wire [31:0]      WB_DAT_I,
  output reg  [31:0]      WB_DAT_O,
  output reg              WB_ACK_O,
  // analog converter samples and run command (from pins)
  input  wire [W-1:0]     VREF_IN,
  input  wire [W-1:0]     IREF_IN,
  input  wire [W-1:0]     PV_IN,
  input  wire             FORWARD_RUN_CMD,
  // flags and outputs
  output reg              SIGNAL_LOSS_FLAG,
  output reg              SECOND_STAGE_REQUEST,
  output reg  [N_OUT-1:0] LOGIC_OUT,
  output reg              IRQ
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [W-1:0] vref_s;
  wire [W-1:0] iref_s;
  wire [W-1:0] pv_s;
  wire         run_s;

  slsf_sync #(.W(W)) u_sync_v (.clk(CORE_CLK), .rst(RST), .d(VREF_IN), .q(vref_s));
  slsf_sync #(.W(W)) u_sync_i (.clk(CORE_CLK), .rst(RST), .d(IREF_IN), .q(iref_s));
  slsf_sync #(.W(W)) u_sync_p (.clk(CORE_CLK), .rst(RST), .d(PV_IN), .q(pv_s));
  slsf_sync #(.W(1)) u_sync_r (.clk(CORE_CLK), .rst(RST), .d(FORWARD_RUN_CMD), .q(run_s));

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [4:0]         ctrl_r;
  reg  [W-1:0]       start_thr_r;
  reg  [W-1:0]       pv_high_r;
  reg  [W-1:0]       pv_low_r;
  reg  [8*N_OUT-1:0] out_sel_r;
  reg  [3:0]         irq_stat_r;
  reg  [3:0]         irq_mask_r;
  reg                loss_r;
  reg                run_r;
  wire               stage_req;

  wire [1:0] freq_source_select  = ctrl_r[`SLSF_CTRL_SRC_LSB +: 2];
  wire [1:0] pid_feedback_source = ctrl_r[`SLSF_CTRL_PIDF_LSB +: 2];
  wire       pid_en              = ctrl_r[`SLSF_CTRL_PID_EN];

  // byte-lane merge for writes
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          wmerge[8*b +: 8] = dat[8*b +: 8];
    end
  endfunction

  wire        req  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire        wr   = req && WB_WE_I;

  // merged write words, cut to each register's width where they are stored
  wire [31:0] ctrl_wr = wmerge({27'h0, ctrl_r}, WB_DAT_I, WB_SEL_I);
  wire [31:0] thr_wr  = wmerge({{(32-W){1'b0}}, start_thr_r}, WB_DAT_I, WB_SEL_I);
  wire [31:0] high_wr = wmerge({{(32-W){1'b0}}, pv_high_r}, WB_DAT_I, WB_SEL_I);
  wire [31:0] low_wr  = wmerge({{(32-W){1'b0}}, pv_low_r}, WB_DAT_I, WB_SEL_I);
  wire [31:0] osel_wr = wmerge({{(32-8*N_OUT){1'b0}}, out_sel_r}, WB_DAT_I, WB_SEL_I);

  // ----------------------------------------------------------------
  // loss detect
  // ----------------------------------------------------------------
  // current range maps 4 mA to code 12'h333 (4095*4/20); below that is loss
  wire iref_low  = (iref_s < `SLSF_IREF_4MA);
  wire vref_low  = (vref_s < start_thr_r);
  // synchronisers hold zero after reset; ignore them until real samples arrive,
  // else the zero current sample fakes a loss event right after reset
  reg  [1:0] warm_r;
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      warm_r <= 2'b00;
    end else begin
      warm_r <= {warm_r[0], 1'b1};
    end
  end
  // combinational, so it self-clears and never latches a trip
  wire loss_nxt  = warm_r[1] && (freq_source_select == `SLSF_SRC_ANALOG) &&
                   (vref_low || iref_low);

  // ----------------------------------------------------------------
  // second stage
  // ----------------------------------------------------------------
  // pid feedback must name a valid source and pid must be enabled
  wire stage_en = pid_en && (pid_feedback_source != 2'h3);

  slsf_stage #(.W(W)) u_stage (
    .clk        (CORE_CLK),
    .rst        (RST),
    .run        (run_s),
    .enable     (stage_en),
    .pv         (pv_s),
    .low_limit  (pv_low_r),
    .high_limit (pv_high_r),
    .request    (stage_req)
  );

  // ----------------------------------------------------------------
  // output routing
  // ----------------------------------------------------------------
  function route;
    input [7:0] code;
    input       loss;
    input       stage;
    begin
      case (code)
        `SLSF_FN_LOSS:  route = loss;
        `SLSF_FN_STAGE: route = stage;
        default:        route = 1'b0;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : g_out
      always @(posedge CORE_CLK or posedge RST) begin
        if (RST)
          LOGIC_OUT[g] <= 1'b0;
        else
          LOGIC_OUT[g] <= route(out_sel_r[8*g +: 8], loss_nxt, stage_req);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // flags and events
  // ----------------------------------------------------------------
  wire [3:0] ev = {
    SECOND_STAGE_REQUEST & ~stage_req,
    ~SECOND_STAGE_REQUEST & stage_req,
    loss_r & ~loss_nxt,
    ~loss_r & loss_nxt
  };
  wire [31:0] wmask = wmerge(32'h0, WB_DAT_I, WB_SEL_I);

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      loss_r               <= 1'b0;
      run_r                <= 1'b0;
      SIGNAL_LOSS_FLAG     <= 1'b0;
      SECOND_STAGE_REQUEST <= 1'b0;
      irq_stat_r           <= 4'h0;
      IRQ                  <= 1'b0;
    end else begin
      loss_r               <= loss_nxt;
      run_r                <= run_s;
      SIGNAL_LOSS_FLAG     <= loss_nxt;
      // stage request is informational only, no alarm path
      SECOND_STAGE_REQUEST <= stage_req;
      if (wr && WB_ADR_I == `SLSF_OFS_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~wmask[3:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
      IRQ <= |((irq_stat_r | ev) & irq_mask_r &
               ~((wr && WB_ADR_I == `SLSF_OFS_IRQ_STAT) ? (wmask[3:0] & ~ev) : 4'h0));
    end
  end

  // ----------------------------------------------------------------
  // wishbone register access
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_r      <= `SLSF_RST_CTRL;
      start_thr_r <= `SLSF_RST_START_THR;
      pv_high_r   <= `SLSF_RST_PV_HIGH;
      pv_low_r    <= `SLSF_RST_PV_LOW;
      out_sel_r   <= {N_OUT{`SLSF_RST_OUT_SEL}};
      irq_mask_r  <= 4'h0;
      WB_ACK_O    <= 1'b0;
      WB_DAT_O    <= 32'h0;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= 32'h0;
      if (wr) begin
        case (WB_ADR_I)
          `SLSF_OFS_CTRL:      ctrl_r      <= ctrl_wr[4:0];
          `SLSF_OFS_START_THR: start_thr_r <= thr_wr[W-1:0];
          `SLSF_OFS_PV_HIGH:   pv_high_r   <= high_wr[W-1:0];
          `SLSF_OFS_PV_LOW:    pv_low_r    <= low_wr[W-1:0];
          `SLSF_OFS_OUT_SEL:   out_sel_r   <= osel_wr[8*N_OUT-1:0];
          `SLSF_OFS_IRQ_MASK:  irq_mask_r  <= WB_SEL_I[0] ? WB_DAT_I[3:0] : irq_mask_r;
          default: ;
        endcase
      end else if (req) begin
        case (WB_ADR_I)
          `SLSF_OFS_CTRL:      WB_DAT_O <= {27'h0, ctrl_r};
          `SLSF_OFS_START_THR: WB_DAT_O <= {{(32-W){1'b0}}, start_thr_r};
          `SLSF_OFS_PV_HIGH:   WB_DAT_O <= {{(32-W){1'b0}}, pv_high_r};
          `SLSF_OFS_PV_LOW:    WB_DAT_O <= {{(32-W){1'b0}}, pv_low_r};
          `SLSF_OFS_OUT_SEL:   WB_DAT_O <= {{(32-8*N_OUT){1'b0}}, out_sel_r};
          `SLSF_OFS_STATUS:    WB_DAT_O <= {29'h0, run_r, SECOND_STAGE_REQUEST, loss_r};
          `SLSF_OFS_IRQ_STAT:  WB_DAT_O <= {28'h0, irq_stat_r};
          `SLSF_OFS_IRQ_MASK:  WB_DAT_O <= {28'h0, irq_mask_r};
          `SLSF_OFS_VREF:      WB_DAT_O <= {{(32-W){1'b0}}, vref_s};
          `SLSF_OFS_IREF:      WB_DAT_O <= {{(32-W){1'b0}}, iref_s};
          `SLSF_OFS_PV:        WB_DAT_O <= {{(32-W){1'b0}}, pv_s};
          default:             WB_DAT_O <= 32'h0;
        endcase
      end
    end
  end
endmodule // slsf_top

/* slsf_props.sv */
`include "slsf_defs.vh"
module slsf_props #(
  parameter int W     = 12,
  parameter int N_OUT = 3
) (
  // clock and reset
  input wire logic         CORE_CLK,
  input wire logic         RST,
  // wishbone
  input wire logic         WB_CYC_I,
  input wire logic         WB_STB_I,
  input wire logic         WB_WE_I,
  input wire logic [7:0]   WB_ADR_I,
  input wire logic [3:0]   WB_SEL_I,
  input wire logic [31:0]  WB_DAT_I,
  input wire logic [31:0]  WB_DAT_O,
  input wire logic         WB_ACK_O,
  // pins
  input wire logic [W-1:0] VREF_IN,
  input wire logic [W-1:0] IREF_IN,
  input wire logic [W-1:0] PV_IN,
  input wire logic         FORWARD_RUN_CMD,
  input wire logic         SIGNAL_LOSS_FLAG,
  input wire logic         SECOND_STAGE_REQUEST,
  input wire logic         IRQ
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // ------------------------------------------------
  // shadow of source select and start threshold
  // ------------------------------------------------
  logic [1:0]   src_r;
  logic [W-1:0] thr_r;
  logic         loss_exp;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      src_r <= `SLSF_SRC_ANALOG;
      thr_r <= `SLSF_RST_START_THR;
    end else if (WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I == `SLSF_OFS_CTRL) src_r <= WB_DAT_I[1:0];
      if (WB_ADR_I == `SLSF_OFS_START_THR) thr_r <= WB_DAT_I[W-1:0];
    end
  end
  assign loss_exp = (src_r == `SLSF_SRC_ANALOG) && (VREF_IN < thr_r || IREF_IN < `SLSF_IREF_4MA);
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  a_ack_after_req: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  a_loss_level: assert property (
    ($stable(VREF_IN) && $stable(IREF_IN) && !WB_CYC_I)[*6]
    |-> SIGNAL_LOSS_FLAG == loss_exp)
    else $error("loss flag disagrees with inputs");
  a_stage_hold: assert property (
    ($stable(PV_IN) && $stable(FORWARD_RUN_CMD) && !WB_CYC_I)[*6]
    |=> $stable(SECOND_STAGE_REQUEST))
    else $error("stage request moved with steady inputs");
  a_stage_stop: assert property ((!FORWARD_RUN_CMD)[*6] |-> !SECOND_STAGE_REQUEST)
    else $error("stage request high in stop");
  a_stage_needs_run: assert property (
    $rose(SECOND_STAGE_REQUEST)
    |-> $past(FORWARD_RUN_CMD, 3) || $past(FORWARD_RUN_CMD, 4) || $past(FORWARD_RUN_CMD, 5))
    else $error("stage request set without run");
  c_loss: cover property ($rose(SIGNAL_LOSS_FLAG));
  c_stage_off: cover property ($fell(SECOND_STAGE_REQUEST) && FORWARD_RUN_CMD);
  c_irq: cover property ($rose(IRQ));
endmodule // slsf_props
bind slsf_top slsf_props #(.W(W), .N_OUT(N_OUT)) u_props (.CORE_CLK(CORE_CLK), .RST(RST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .VREF_IN(VREF_IN), .IREF_IN(IREF_IN), .PV_IN(PV_IN), .FORWARD_RUN_CMD(FORWARD_RUN_CMD),
  .SIGNAL_LOSS_FLAG(SIGNAL_LOSS_FLAG), .SECOND_STAGE_REQUEST(SECOND_STAGE_REQUEST), .IRQ(IRQ));

/* slsf_stage2_drv.sv */
module slsf_stage2_drv (
  // clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // run input from the first stage
  input wire logic  run_in,
  // state
  output logic      running
);
  timeunit 1ns;
  timeprecision 1ps;
  // second drive runs while its run input is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) running <= 1'b0;
    else running <= run_in;
  end
endmodule // slsf_stage2_drv

/* signal_loss_and_stage2_flags_test.sv */
`include "slsf_defs.vh"
module signal_loss_and_stage2_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, fwd = 0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [11:0] vref = 12'h800, iref = 12'h800, pv = 12'h800;
  wire  [31:0] dat_o;
  wire  [2:0]  lout;
  wire         ack, loss, stage, irq, running;
  int          error_cnt = 0, cmp_count = 0;
  always #10 clk = ~clk;
  slsf_top dut (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .VREF_IN(vref), .IREF_IN(iref), .PV_IN(pv), .FORWARD_RUN_CMD(fwd),
    .SIGNAL_LOSS_FLAG(loss), .SECOND_STAGE_REQUEST(stage), .LOGIC_OUT(lout), .IRQ(irq));
  slsf_stage2_drv u_far (.clk(clk), .rst(rst), .run_in(lout[1]), .running(running));
  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // drive pins, let them pass the synchroniser, compare both flags
  task automatic step(input logic [11:0] v, i, p, input logic f, l, s);
    @(posedge clk);
    vref <= v;
    iref <= i;
    pv <= p;
    fwd <= f;
    repeat (8) @(posedge clk);
    chk(32'({loss, stage}), 32'({l, s}));
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic test_regs;
    rd(`SLSF_OFS_IRQ_STAT, 32'h0);
    rd(`SLSF_OFS_CTRL, 32'h11);
    rd(`SLSF_OFS_PV_HIGH, 32'hfff);
    rd(`SLSF_OFS_OUT_SEL, 32'h0006_0606);
    rd(8'hfc, 32'h0);
    wb(1'b1, `SLSF_OFS_STATUS, 32'hffff_ffff);
    rd(`SLSF_OFS_STATUS, 32'h0);
  endtask
  task automatic test_loss;
    wb(1'b1, `SLSF_OFS_START_THR, 32'h100);
    step(12'h0ff, 12'h800, 12'h800, 0, 1, 0);
    rd(`SLSF_OFS_STATUS, 32'h1);
    step(12'h100, 12'h800, 12'h800, 0, 0, 0);
    step(12'h800, 12'h332, 12'h800, 0, 1, 0);
    step(12'h800, 12'h333, 12'h800, 0, 0, 0);
    step(12'h800, 12'h332, 12'h800, 0, 1, 0);
    wb(1'b1, `SLSF_OFS_CTRL, 32'h10);
    step(12'h0ff, 12'h332, 12'h800, 0, 0, 0);
    wb(1'b1, `SLSF_OFS_CTRL, 32'h11);
    step(12'h800, 12'h800, 12'h800, 0, 0, 0);
  endtask
  task automatic test_stage;
    wb(1'b1, `SLSF_OFS_PV_LOW, 32'h400);
    wb(1'b1, `SLSF_OFS_PV_HIGH, 32'hc00);
    step(12'h800, 12'h800, 12'h300, 0, 0, 0);
    step(12'h800, 12'h800, 12'h300, 1, 0, 1);
    step(12'h800, 12'h800, 12'hc00, 1, 0, 1);
    step(12'h800, 12'h800, 12'hc01, 1, 0, 0);
    step(12'h800, 12'h800, 12'h400, 1, 0, 0);
    step(12'h800, 12'h800, 12'h3ff, 1, 0, 1);
    step(12'h800, 12'h800, 12'h3ff, 0, 0, 0);
    wb(1'b1, `SLSF_OFS_CTRL, 32'h1d);
    step(12'h800, 12'h800, 12'h3ff, 1, 0, 0);
    wb(1'b1, `SLSF_OFS_CTRL, 32'h11);
    step(12'h800, 12'h800, 12'h3ff, 1, 0, 1);
    chk(32'(irq), 32'h0);
    step(12'h800, 12'h800, 12'h800, 0, 0, 0);
  endtask
  task automatic test_route;
    wb(1'b1, `SLSF_OFS_OUT_SEL, 32'h0000_0706);
    step(12'h0ff, 12'h800, 12'h3ff, 1, 1, 1);
    chk(32'(lout), 32'h3);
    chk(32'(running), 32'h1);
    rd(`SLSF_OFS_STATUS, 32'h7);
    rd(`SLSF_OFS_VREF, 32'h0ff);
    rd(`SLSF_OFS_IREF, 32'h800);
    rd(`SLSF_OFS_PV, 32'h3ff);
    wb(1'b1, `SLSF_OFS_OUT_SEL, 32'h0000_0507);
    step(12'h800, 12'h800, 12'h3ff, 1, 0, 1);
    chk(32'(lout), 32'h1);
    chk(32'(running), 32'h0);
    step(12'h800, 12'h800, 12'h800, 0, 0, 0);
  endtask
  task automatic test_irq;
    wb(1'b1, `SLSF_OFS_IRQ_STAT, 32'hf);
    wb(1'b1, `SLSF_OFS_IRQ_MASK, 32'h1);
    step(12'h0ff, 12'h800, 12'h800, 0, 1, 0);
    chk(32'(irq), 32'h1);
    rd(`SLSF_OFS_IRQ_STAT, 32'h1);
    wb(1'b1, `SLSF_OFS_IRQ_MASK, 32'h0);
    step(12'h0ff, 12'h800, 12'h800, 0, 1, 0);
    chk(32'(irq), 32'h0);
    wb(1'b1, `SLSF_OFS_IRQ_MASK, 32'h1);
    wb(1'b1, `SLSF_OFS_IRQ_STAT, 32'h1);
    step(12'h800, 12'h800, 12'h800, 0, 0, 0);
    chk(32'(irq), 32'h0);
    rd(`SLSF_OFS_IRQ_STAT, 32'h2);
    wb(1'b1, `SLSF_OFS_IRQ_STAT, 32'hf);
    step(12'h800, 12'h800, 12'h3ff, 1, 0, 1);
    step(12'h800, 12'h800, 12'h3ff, 0, 0, 0);
    rd(`SLSF_OFS_IRQ_STAT, 32'hc);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    test_regs;
    test_loss;
    test_stage;
    test_route;
    test_irq;
    test_done;
  end
  initial begin
    #200us;
    error_cnt++;
    test_done;
  end
endmodule // signal_loss_and_stage2_flags_test
